// ===== include/pasr_conv_if.sv
// Purpose: Carrier between sequencer and one converter
// Assumes: Single clock domain
// Notes: stb marks the cycle a sample is taken
`timescale 1ns/10ps
`default_nettype none
interface pasr_conv_if;
  import pasr_pkg::*;
  logic [CODE_W-1:0] ain;
  logic stb;
  logic [CODE_W-1:0] dout;
  modport ctl (output ain, input stb, input dout);
  modport cnv (input ain, output stb, output dout);
endinterface
`default_nettype wire

// ===== include/pasr_pkg.sv
// Purpose: Shared constants and types for the pixel readout block
// Assumes: 50 MHz system clock
// Notes: Array is 2048 x 2048, read as column pairs
package pasr_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CONV_RATE_HZ = 10_000_000;
  localparam int CONV_CYC_MIN = CLK_HZ / CONV_RATE_HZ;
  localparam int CODE_W = 10;
  localparam int PIPE_DEPTH = 2;
  localparam int NUM_CONV = 2;
  localparam int ROW_W = 11;
  localparam int PAIR_W = 10;
  localparam int CNT_W = 16;
  localparam int RR_W = 4;
  localparam int CFG_W = 3 + RR_W + CNT_W;
  localparam logic [ROW_W-1:0] LAST_ROW = 11'h7ff;
  localparam logic [PAIR_W-1:0] LAST_PAIR = 10'h3ff;
  localparam logic [CNT_W-1:0] RST_CYC = 16'h0004;
  localparam logic [CNT_W-1:0] SMP_CYC = 16'h0004;
  localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
  typedef enum logic [2:0] {
    I_IDLE, I_RESET, I_INTEG, I_WAIT, I_SAMPLE, I_REREAD
  } pasr_integ_type;
  typedef enum logic {R_IDLE, R_READ} pasr_read_type;
endpackage

// ===== verification/pasr_ctl_model.sv
// Purpose: Camera controller model driving both conversion clocks
// Assumes: Conversion period of six clock_i cycles
// Notes: Clock stands high while disabled, so no falls outside readout
`timescale 1ns/10ps
`default_nettype none
module pasr_ctl_model
  import pasr_pkg::*;
(
  input wire logic clock_i,
  input wire logic en_i,
  input wire logic [CODE_W-1:0] adc_even_i,
  input wire logic [CODE_W-1:0] adc_odd_i,
  output logic [NUM_CONV-1:0] conv_clk_o,
  output logic cap_o,
  output logic [CODE_W-1:0] even_o,
  output logic [CODE_W-1:0] odd_o
);
  int ph = 0;
  logic fell = 1'b0;
  initial begin
    conv_clk_o = 2'h3;
    cap_o = 1'b0;
    even_o = 10'h000;
    odd_o = 10'h000;
  end
  always @(posedge clock_i) begin
    cap_o <= 1'b0;
    if (en_i !== 1'b1) begin
      ph <= 0;
      fell <= 1'b0;
      conv_clk_o <= 2'h3;
    end else begin
      ph <= (ph == 5) ? 0 : ph + 1;
      conv_clk_o <= (ph >= 2 && ph < 5) ? 2'h0 : 2'h3;
      if (ph == 2) fell <= 1'b1;
      if (ph == 1 && fell) begin
        cap_o <= 1'b1;
        even_o <= adc_even_i;
        odd_o <= adc_odd_i;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/pixel_adc_shutter_readout_test.sv
// Purpose: Self-checking bench for the readout block
// Assumes: Pixel codes follow the address combinationally
// Notes: Frames are cut short; a full frame would run too long
`timescale 1ns/10ps
`default_nettype none
module pixel_adc_shutter_readout_test;
  import pasr_pkg::*;
  logic clock_i = 1'b0, nrst_i = 1'b0, shutter_start_i = 1'b0, overlap_i = 1'b0;
  logic repeated_read_mode_i = 1'b0, en = 1'b0, cap, pix_reset_o, pix_sample_o;
  logic read_busy_o, frame_end_o;
  logic [RR_W-1:0] rr_reads_i = 4'h0;
  logic [CNT_W-1:0] integ_len_i = 16'h0000;
  logic [CODE_W-1:0] pix_even_i, pix_odd_i, adc_even_o, adc_odd_o, cap_e, cap_o;
  logic [ROW_W-1:0] row_o, col_o;
  logic [NUM_CONV-1:0] conv_clk;
  logic [CODE_W-1:0] mask = 10'h000;
  logic [CODE_W-1:0] q[$];
  int n_fail = 0, compares = 0, cyc = 0, seed = 87, n, k;
  always #10 clock_i = ~clock_i;
  function automatic logic [CODE_W-1:0] pix(int r, int c);
    return CODE_W'((r * 37 + c * 11) ^ int'(mask));
  endfunction
  assign pix_even_i = pix(int'(row_o), int'(col_o));
  assign pix_odd_i = pix(int'(row_o), int'(col_o) + 1);
  pasr_readout dut_u (.clock_i(clock_i), .nrst_i(nrst_i), .conv_clk_i(conv_clk),
    .shutter_start_i(shutter_start_i), .overlap_i(overlap_i),
    .repeated_read_mode_i(repeated_read_mode_i), .rr_reads_i(rr_reads_i),
    .integ_len_i(integ_len_i), .pix_even_i(pix_even_i), .pix_odd_i(pix_odd_i),
    .pix_reset_o(pix_reset_o), .pix_sample_o(pix_sample_o), .row_o(row_o), .col_o(col_o),
    .read_busy_o(read_busy_o), .frame_end_o(frame_end_o), .adc_even_o(adc_even_o),
    .adc_odd_o(adc_odd_o));
  pasr_ctl_model ctl_u (.clock_i(clock_i), .en_i(en), .adc_even_i(adc_even_o),
    .adc_odd_i(adc_odd_o), .conv_clk_o(conv_clk), .cap_o(cap), .even_o(cap_e),
    .odd_o(cap_o));
  task report_and_stop;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop;
    end
  end
  task chk_code(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_pos(input logic [ROW_W-1:0] got, input logic [ROW_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge clock_i);
    #1;
  endtask
  task pulse_start;
    @(posedge clock_i);
    shutter_start_i <= 1'b1;
    @(posedge clock_i);
    shutter_start_i <= 1'b0;
    #1;
  endtask
  task count_high(input bit sel);
    n = 0;
    while (((sel ? pix_sample_o : pix_reset_o) !== 1'b1) && n < 200) begin
      n++;
      step;
    end
    n = 0;
    while ((sel ? pix_sample_o : pix_reset_o) === 1'b1) begin
      n++;
      step;
    end
  endtask
  task run_frame(input bit ovl);
    @(posedge clock_i);
    overlap_i <= ovl;
    integ_len_i <= 16'($random(seed)) & 16'h003f;
    repeated_read_mode_i <= 1'($random(seed)) & !ovl;
    rr_reads_i <= 4'($random(seed));
    pulse_start;
    count_high(1'b0);
    chk_pos(11'(n), 11'h004);
    count_high(1'b1);
    chk_pos(11'(n), 11'h004);
    chk_pos({10'h000, read_busy_o}, 11'h001);
    $display("test frame start done");
  endtask
  task read_pairs(input int num);
    q.delete();
    k = 0;
    en = 1'b1;
    while (k < num) begin
      step;
      if (cap === 1'b1) begin
        q.push_back(pix(k / 1024, 2 * (k % 1024)));
        q.push_back(pix(k / 1024, 2 * (k % 1024) + 1));
        k++;
        chk_pos(col_o, 11'(2 * (k % 1024)));
        chk_pos(row_o, 11'(k / 1024));
        if (q.size() > 4) begin
          chk_code(cap_e, q.pop_front());
          chk_code(cap_o, q.pop_front());
        end
      end
    end
    chk_pos({10'h000, frame_end_o}, 11'h000);
    en = 1'b0;
    $display("test readout done");
  endtask
  initial begin
    mask = CODE_W'($random(seed));
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    step;
    chk_pos({7'h00, pix_reset_o, pix_sample_o, read_busy_o, frame_end_o}, 11'h000);
    chk_code(adc_even_o | adc_odd_o, CODE_RST);
    run_frame(1'b0);
    read_pairs(1030);
    pulse_start;
    count_high(1'b0);
    chk_pos(11'(n), 11'h000);
    chk_pos({10'h000, read_busy_o}, 11'h001);
    $display("test sequential refusal done");
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (3) step;
    chk_pos({7'h00, pix_reset_o, pix_sample_o, read_busy_o, frame_end_o}, 11'h000);
    @(posedge clock_i);
    nrst_i <= 1'b1;
    run_frame(1'b1);
    read_pairs(20);
    pulse_start;
    count_high(1'b0);
    chk_pos(11'(n), 11'h004);
    chk_pos({10'h000, read_busy_o}, 11'h001);
    $display("test overlap done");
    report_and_stop;
  end
endmodule
`default_nettype wire

// ===== verilog/pasr_converter.sv
// Purpose: One converter channel with two-stage output pipeline
// Assumes: Conversion clock pin is much slower than clock_i
// Notes: Falling edge detected after a two-flop synchroniser
`timescale 1ns/10ps
`default_nettype none
module pasr_converter
  import pasr_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic conv_clk_i,
  pasr_conv_if.cnv cnv
);
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic [CODE_W-1:0] pipe_r [PIPE_DEPTH];
  logic [CODE_W-1:0] h0_r;
  logic [CODE_W-1:0] h1_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= conv_clk_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign cnv.stb = sync3_r & ~sync2_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_r[i] <= CODE_RST;
      end
      cnv.dout <= CODE_RST;
    end else if (cnv.stb) begin
      pipe_r[0] <= cnv.ain;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_r[i] <= pipe_r[i-1];
      end
      cnv.dout <= pipe_r[PIPE_DEPTH-1];
    end
  end

  // Reference history for the latency check
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      h0_r <= CODE_RST;
      h1_r <= CODE_RST;
    end else if (cnv.stb) begin
      h0_r <= cnv.ain;
      h1_r <= h0_r;
    end
  end

  property p_latency;
    @(posedge clock_i) disable iff (!nrst_i)
    cnv.stb |=> (cnv.dout == $past(h1_r));
  endproperty
  a_latency: assert property (p_latency) else $error("Output not two samples late");

  property p_hold;
    @(posedge clock_i) disable iff (!nrst_i)
    !cnv.stb |=> $stable(cnv.dout);
  endproperty
  a_hold: assert property (p_hold) else $error("Output changed between edges");

  property p_fall_only;
    @(posedge clock_i) disable iff (!nrst_i)
    cnv.stb |-> ($past(conv_clk_i, 3) && !$past(conv_clk_i, 2));
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("Sample off falling edge");

  property p_one_code;
    @(posedge clock_i) disable iff (!nrst_i)
    cnv.stb |=> !cnv.stb;
  endproperty
  a_one_code: assert property (p_one_code) else $error("Two samples on one edge");
endmodule
`default_nettype wire

// ===== verilog/pasr_readout.sv
// Purpose: Snapshot shutter sequencer and dual converter readout
// Assumes: Pixel inputs follow row_o and col_o combinationally
// Notes: Control pins are synchronised before use
// Notes on behaviour
// - Two independent converters, each yielding 10-bit codes at about 10 Msamples/s.
// - Even columns go to one converter, odd columns to the other.
// - Each converter samples on the falling edge of its conversion clock.
// - Result appears two conversion clock cycles after its sampling edge.
// - Snapshot mode resets every pixel at once to start integration.
// - Integration ends with one global transfer onto pixel storage nodes.
// - After the global sample, stored values are read line by line.
// - Next integration may overlap readout or follow it; both supported.
// - Repeated-read mode reads pixels several times after only one reset.
`timescale 1ns/10ps
`default_nettype none
module pasr_readout
  import pasr_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [NUM_CONV-1:0] conv_clk_i,
  input wire logic shutter_start_i,
  input wire logic overlap_i,
  input wire logic repeated_read_mode_i,
  input wire logic [RR_W-1:0] rr_reads_i,
  input wire logic [CNT_W-1:0] integ_len_i,
  input wire logic [CODE_W-1:0] pix_even_i,
  input wire logic [CODE_W-1:0] pix_odd_i,
  output logic pix_reset_o,
  output logic pix_sample_o,
  output logic [ROW_W-1:0] row_o,
  output logic [ROW_W-1:0] col_o,
  output logic read_busy_o,
  output logic frame_end_o,
  output logic [CODE_W-1:0] adc_even_o,
  output logic [CODE_W-1:0] adc_odd_o
);
  logic [CFG_W-1:0] cfg1_r;
  logic [CFG_W-1:0] cfg2_r;
  logic start_prev_r;
  logic start_pend_r;
  logic start_ok;
  logic ovl_s;
  logic rr_s;
  logic [RR_W-1:0] reads_s;
  logic [CNT_W-1:0] len_s;
  pasr_integ_type ist_r;
  pasr_read_type rst_r;
  logic [CNT_W-1:0] cnt_r;
  logic [RR_W-1:0] rr_left_r;
  logic rd_go;
  logic rd_done;
  logic [PAIR_W-1:0] pair_r;
  logic [ROW_W-1:0] row_r;
  logic load_r;
  logic [NUM_CONV-1:0] taken_r;
  logic [CODE_W-1:0] hold_r [NUM_CONV];
  logic [NUM_CONV-1:0] stb;
  logic pair_done;

  pasr_conv_if cif [NUM_CONV] ();

  for (genvar g = 0; g < NUM_CONV; g++) begin : g_conv
    pasr_converter u_conv (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .conv_clk_i(conv_clk_i[g]),
      .cnv(cif[g])
    );
    assign cif[g].ain = hold_r[g];
    assign stb[g] = cif[g].stb;
  end

  assign adc_even_o = cif[0].dout;
  assign adc_odd_o = cif[1].dout;

  // Pin synchroniser
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg1_r <= '0;
      cfg2_r <= '0;
      start_prev_r <= 1'b0;
    end else begin
      cfg1_r <= {shutter_start_i, overlap_i, repeated_read_mode_i, rr_reads_i, integ_len_i};
      cfg2_r <= cfg1_r;
      start_prev_r <= cfg2_r[CFG_W-1];
    end
  end

  assign ovl_s = cfg2_r[CFG_W-2];
  assign rr_s = cfg2_r[CFG_W-3];
  assign reads_s = cfg2_r[CNT_W +: RR_W];
  assign len_s = cfg2_r[CNT_W-1:0];

  assign start_ok = start_pend_r && (ist_r == I_IDLE) && (ovl_s || rst_r == R_IDLE);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_pend_r <= 1'b0;
    end else if (cfg2_r[CFG_W-1] && !start_prev_r) begin
      start_pend_r <= 1'b1;
    end else if (start_ok) begin
      start_pend_r <= 1'b0;
    end
  end

  assign rd_go = (ist_r == I_SAMPLE) && (cnt_r == '0);

  // Shutter sequence
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ist_r <= I_IDLE;
      cnt_r <= '0;
      rr_left_r <= '0;
    end else begin
      unique case (ist_r)
        I_IDLE: begin
          if (start_ok) begin
            ist_r <= I_RESET;
            cnt_r <= RST_CYC - 16'h0001;
            rr_left_r <= rr_s ? reads_s : '0;
          end
        end
        I_RESET: begin
          if (cnt_r == '0) begin
            ist_r <= I_INTEG;
            cnt_r <= len_s;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        I_INTEG: begin
          if (cnt_r == '0) begin
            ist_r <= I_WAIT;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        I_WAIT: begin
          if (rst_r == R_IDLE) begin
            ist_r <= I_SAMPLE;
            cnt_r <= SMP_CYC - 16'h0001;
          end
        end
        I_SAMPLE: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 16'h0001;
          end else if (rr_left_r != '0) begin
            ist_r <= I_REREAD;
            rr_left_r <= rr_left_r - 4'h1;
          end else begin
            ist_r <= I_IDLE;
          end
        end
        I_REREAD: begin
          if (rd_done) begin
            ist_r <= I_INTEG;
            cnt_r <= len_s;
          end
        end
      endcase
    end
  end

  assign pix_reset_o = (ist_r == I_RESET);
  assign pix_sample_o = (ist_r == I_SAMPLE);

  assign pair_done = &taken_r;
  assign rd_done = (rst_r == R_READ) && pair_done && (pair_r == LAST_PAIR)
                   && (row_r == LAST_ROW);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_r <= R_IDLE;
      pair_r <= '0;
      row_r <= '0;
      load_r <= 1'b0;
    end else begin
      load_r <= 1'b0;
      unique case (rst_r)
        R_IDLE: begin
          if (rd_go) begin
            rst_r <= R_READ;
            pair_r <= '0;
            row_r <= '0;
            load_r <= 1'b1;
          end
        end
        R_READ: begin
          if (pair_done) begin
            load_r <= 1'b1;
            if (pair_r != LAST_PAIR) begin
              pair_r <= pair_r + 10'h001;
            end else if (row_r != LAST_ROW) begin
              pair_r <= '0;
              row_r <= row_r + 11'h001;
            end else begin
              rst_r <= R_IDLE;
              load_r <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      taken_r <= '0;
      hold_r[0] <= CODE_RST;
      hold_r[1] <= CODE_RST;
    end else begin
      if (load_r) begin
        hold_r[0] <= pix_even_i;
        hold_r[1] <= pix_odd_i;
        taken_r <= '0;
      end else if (rst_r == R_READ) begin
        taken_r <= pair_done ? stb : (taken_r | stb);
      end else begin
        taken_r <= '0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_end_o <= 1'b0;
    end else begin
      frame_end_o <= rd_done;
    end
  end

  assign row_o = row_r;
  assign col_o = {pair_r, 1'b0};
  assign read_busy_o = (rst_r == R_READ);

  sequence s_reset_pulse;
    pix_reset_o [*4] ##1 !pix_reset_o;
  endsequence
  property p_reset_len;
    @(posedge clock_i) disable iff (!nrst_i)
    $rose(pix_reset_o) |-> s_reset_pulse;
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("Global reset width wrong");

  property p_sample_free;
    @(posedge clock_i) disable iff (!nrst_i)
    pix_sample_o |-> !read_busy_o;
  endproperty
  a_sample_free: assert property (p_sample_free) else $error("Sample during readout");

  property p_read_follows;
    @(posedge clock_i) disable iff (!nrst_i)
    $fell(pix_sample_o) |-> read_busy_o && row_o == '0 && col_o == '0;
  endproperty
  a_read_follows: assert property (p_read_follows) else $error("Readout did not start");

  property p_row_step;
    @(posedge clock_i) disable iff (!nrst_i)
    read_busy_o && $changed(row_o) |-> row_o == $past(row_o) + 11'h001 && col_o == '0;
  endproperty
  a_row_step: assert property (p_row_step) else $error("Line order broken");

  property p_parity;
    @(posedge clock_i) disable iff (!nrst_i)
    load_r |=> col_o[0] == 1'b0 && cif[0].ain == $past(pix_even_i)
               && cif[1].ain == $past(pix_odd_i);
  endproperty
  a_parity: assert property (p_parity) else $error("Column parity routing wrong");

  property p_overlap;
    @(posedge clock_i) disable iff (!nrst_i)
    $rose(pix_reset_o) && $past(read_busy_o) |-> $past(ovl_s);
  endproperty
  a_overlap: assert property (p_overlap) else $error("Reset during read unasked");

  sequence s_reread_end;
    ist_r == I_REREAD && rd_done;
  endsequence
  property p_no_reset;
    @(posedge clock_i) disable iff (!nrst_i)
    s_reread_end |=> ist_r == I_INTEG ##1 !pix_reset_o;
  endproperty
  a_no_reset: assert property (p_no_reset) else $error("Reset between repeated reads");
endmodule
`default_nettype wire
